// ==== verilog/rfo_consts.vh ====
// Register offsets, field positions and reset values of the framing option registers.
// Included by the framing option bank; the decode helper does not include it.
`ifndef RFO_CONSTS_VH
`define RFO_CONSTS_VH
`define RFO_IDX_TYPE_B 8'h07
`define RFO_IDX_STREAM 8'h08
`define RFO_IDX_AUX 8'h09
`define RFO_ADDR_TYPE_B 12'h01C
`define RFO_ADDR_STREAM 12'h020
`define RFO_ADDR_AUX 12'h024
`define RFO_RST_TYPE_B 8'h00
`define RFO_RST_STREAM 8'h00
`define RFO_RST_AUX 8'h04
`define RFO_MASK_STREAM 8'h7F
`define RFO_TB_GAP_HI 7
`define RFO_TB_GAP_LO 6
`define RFO_TB_NO_SOF 5
`define RFO_TB_NO_EOF 4
`define RFO_TB_EOF12 3
`define RFO_TB_PHC 2
`define RFO_TB_PRE_HI 1
`define RFO_TB_PRE_LO 0
`define RFO_ST_SCF_HI 6
`define RFO_ST_SCF_LO 5
`define RFO_ST_SCP_HI 4
`define RFO_ST_SCP_LO 3
`define RFO_ST_STX_HI 2
`define RFO_ST_STX_LO 0
`define RFO_AX_NO_CRC 7
`define RFO_AX_CRC_FIFO 6
`define RFO_AX_AM 5
`define RFO_AX_FD 4
`define RFO_AX_TRI 3
`define RFO_AX_TOL 2
`define RFO_AX_N_HI 1
`define RFO_AX_N_LO 0
`define RFO_GAP_LONG 8'd80
`define RFO_GAP_MID 8'd64
`define RFO_GAP_SHORT 8'd32
`define RFO_PRE_BASE 7'd48
`define RFO_PRE_STEP 7'd16
`define RFO_EOF_MAX_SHORT 4'd11
`define RFO_EOF_MAX_LONG 4'd12
`define RFO_EOF_MIN 4'd10
`define RFO_RATE_128 2'd0
`define RFO_RATE_16 2'd3
`endif

// ==== verilog/rfo_decode.v ====
// Decoder of stream mode field codes into divider exponents of the carrier.
// Assumes the field codes come from the option bank registers on the same clock.
`timescale 1ns/1ns
`default_nettype none
module rfo_decode (
  input wire pclk,
  input wire presetn,
  input wire bpsk_mode,
  input wire [1:0] scf_code,
  input wire [1:0] scp_code,
  input wire [2:0] stx_code,
  output reg [2:0] sc_div_log2_r,
  output reg [3:0] pulses_r,
  output reg [2:0] tx_div_log2_r,
  output reg code_bad_r
);
  reg [2:0] sc_nxt;
  reg [3:0] pulses_nxt;
  reg bad_nxt;
  always @* begin
    bad_nxt = 1'b0;
    if (bpsk_mode) begin
      sc_nxt = 3'd4 - {1'b0, scf_code};
      if (scf_code == 2'b11) begin
        bad_nxt = 1'b1;
      end
    end else begin
      sc_nxt = 3'd6 - {1'b0, scf_code};
    end
    pulses_nxt = 4'd1 << scp_code;
    if (scp_code == 2'b00 && !bpsk_mode) begin
      bad_nxt = 1'b1;
    end
    if (stx_code == 3'b111) begin
      bad_nxt = 1'b1;
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_div_log2_r <= 3'd6;
      pulses_r <= 4'd1;
      tx_div_log2_r <= 3'd7;
      code_bad_r <= 1'b1;
    end else begin
      sc_div_log2_r <= sc_nxt;
      pulses_r <= pulses_nxt;
      tx_div_log2_r <= 3'd7 - stx_code;
      code_bad_r <= bad_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/rfo_bank.v ====
// Framing option register bank: type-B/preamble, stream mode and auxiliary options over APB.
// Assumes a single pclk domain; framing logic inputs come from logic on the same clock.
// Function
// - Gap code picks minimum card response gap
// - Skip start marker bit accepts no-SOF frames
// - Skip end marker bit accepts no-EOF frames
// - Long end marker widens EOF to 12
// - Fastest rate (rate code 3) ignores long end marker
// - Bit 2 raises phase change tolerance
// - Preamble code gives 48 to 96
// - Subcarrier code maps frequency per mode
// - Pulse code gives one to eight pulses
// - Period code gives fc/128 to fc/2; code 7 gives fc/1 and flags the code bad
// - CRC skip bit disables CRC check
// - REQA, WUPA, anticollision skip CRC automatically
// - CRC bytes kept in FIFO and count
// - Modulation bit, preset by analog command
// - Field detector enable uses peer threshold
// - Tristate driver during OOK keying
// - Tolerance bit defaults one, tolerant decoding
// - Bits 1:0 give n for field commands
// - Defaults at power-up and set-default
`timescale 1ns/1ns
`default_nettype none
`include "rfo_consts.vh"
module rfo_bank (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire set_default_cmd,
  input wire analog_preset_cmd,
  input wire analog_preset_am,
  input wire reqa_wupa_sent,
  input wire anticollision_frame,
  input wire bpsk_mode,
  input wire [1:0] rx_rate,
  input wire ook_keying,
  output reg [7:0] min_response_gap,
  output reg accept_no_sof,
  output reg accept_no_eof,
  output reg [3:0] eof_min_etu,
  output reg [3:0] eof_max_etu,
  output reg phase_change_tolerance,
  output reg [6:0] preamble_len,
  output reg rx_crc_check,
  output reg crc_to_fifo,
  output reg tx_modulation_select,
  output reg field_detector_enable,
  output reg driver_tristate,
  output reg rx_tolerant,
  output reg [1:0] field_cmd_n,
  output reg [2:0] subcarrier_div_log2,
  output reg [3:0] pulses_per_period,
  output reg [2:0] tx_div_log2,
  output reg stream_code_bad
);
  reg [7:0] type_b_r;
  reg [7:0] stream_r;
  reg [7:0] aux_r;
  reg [7:0] type_b_nxt;
  reg [7:0] stream_nxt;
  reg [7:0] aux_nxt;
  reg [31:0] rd_nxt;
  reg err_nxt;
  wire [2:0] sc_w;
  wire [3:0] pl_w;
  wire [2:0] tx_w;
  wire bad_w;

  // Next values of the framing controls
  reg [7:0] gap_nxt;
  reg no_sof_nxt;
  reg no_eof_nxt;
  reg [3:0] eof_min_nxt;
  reg [3:0] eof_max_nxt;
  reg phc_nxt;
  reg [6:0] pre_nxt;
  reg crc_chk_nxt;
  reg crc_fifo_nxt;
  reg am_nxt;
  reg fd_nxt;
  reg tri_nxt;
  reg tol_nxt;
  reg [1:0] n_nxt;
  reg [2:0] sc_div_nxt;
  reg [3:0] pulse_cnt_nxt;
  reg [2:0] tx_div_nxt;
  reg code_bad_nxt;

  wire access = psel && penable;
  wire wr_en = access && pwrite && pready;

  function [7:0] rfo_merge;
    input [7:0] old;
    input [31:0] wd;
    input [3:0] strb;
    begin
      rfo_merge = strb[0] ? wd[7:0] : old;
    end
  endfunction

  function [1:0] rfo_hit;
    input [11:0] a;
    begin
      if (a == `RFO_ADDR_TYPE_B) begin
        rfo_hit = 2'd1;
      end else if (a == `RFO_ADDR_STREAM) begin
        rfo_hit = 2'd2;
      end else if (a == `RFO_ADDR_AUX) begin
        rfo_hit = 2'd3;
      end else begin
        rfo_hit = 2'd0;
      end
    end
  endfunction

  // Register writes; set-default overrides any write in the same cycle
  always @* begin
    type_b_nxt = type_b_r;
    stream_nxt = stream_r;
    aux_nxt = aux_r;
    if (wr_en) begin
      case (rfo_hit(paddr))
        2'd1: begin
          type_b_nxt = rfo_merge(type_b_r, pwdata, pstrb);
        end
        2'd2: begin
          stream_nxt = rfo_merge(stream_r, pwdata, pstrb) & `RFO_MASK_STREAM;
        end
        2'd3: begin
          aux_nxt = rfo_merge(aux_r, pwdata, pstrb);
        end
        default: begin
          aux_nxt = aux_r;
        end
      endcase
    end
    if (analog_preset_cmd) begin
      aux_nxt[`RFO_AX_AM] = analog_preset_am;
    end
    if (set_default_cmd) begin
      type_b_nxt = `RFO_RST_TYPE_B;
      stream_nxt = `RFO_RST_STREAM;
      aux_nxt = `RFO_RST_AUX;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      type_b_r <= `RFO_RST_TYPE_B;
      stream_r <= `RFO_RST_STREAM;
      aux_r <= `RFO_RST_AUX;
    end else begin
      type_b_r <= type_b_nxt;
      stream_r <= stream_nxt;
      aux_r <= aux_nxt;
    end
  end

  // Read mux; unmapped addresses answer zero with an error
  always @* begin
    rd_nxt = 32'h00000000;
    err_nxt = 1'b0;
    case (rfo_hit(paddr))
      2'd1: begin
        rd_nxt = {24'h000000, type_b_r};
      end
      2'd2: begin
        rd_nxt = {24'h000000, stream_r};
      end
      2'd3: begin
        rd_nxt = {24'h000000, aux_r};
      end
      default: begin
        err_nxt = 1'b1;
      end
    endcase
  end

  // One wait state: pready rises one cycle into the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= access && !pready;
      if (access && !pready) begin
        prdata <= pwrite ? 32'h00000000 : rd_nxt;
        pslverr <= err_nxt;
      end else begin
        prdata <= 32'h00000000;
        pslverr <= 1'b0;
      end
    end
  end

  rfo_decode u_dec (
    .pclk(pclk),
    .presetn(presetn),
    .bpsk_mode(bpsk_mode),
    .scf_code(stream_r[`RFO_ST_SCF_HI:`RFO_ST_SCF_LO]),
    .scp_code(stream_r[`RFO_ST_SCP_HI:`RFO_ST_SCP_LO]),
    .stx_code(stream_r[`RFO_ST_STX_HI:`RFO_ST_STX_LO]),
    .sc_div_log2_r(sc_w),
    .pulses_r(pl_w),
    .tx_div_log2_r(tx_w),
    .code_bad_r(bad_w)
  );

  // Framing decode; every value here is registered below
  always @* begin
    if (type_b_r[`RFO_TB_GAP_HI:`RFO_TB_GAP_LO] == 2'b01) begin
      if (rx_rate == `RFO_RATE_128) begin
        gap_nxt = `RFO_GAP_MID;
      end else begin
        gap_nxt = `RFO_GAP_SHORT;
      end
    end else begin
      // Unused codes fall back to the safe long gap
      gap_nxt = `RFO_GAP_LONG;
    end
    no_sof_nxt = type_b_r[`RFO_TB_NO_SOF];
    no_eof_nxt = type_b_r[`RFO_TB_NO_EOF];
    eof_min_nxt = `RFO_EOF_MIN;
    if (type_b_r[`RFO_TB_EOF12]) begin
      eof_max_nxt = `RFO_EOF_MAX_LONG;
    end else begin
      eof_max_nxt = `RFO_EOF_MAX_SHORT;
    end
    // the fastest rate (code 3) cannot tell 11 from 12 etu, so the wide window stands
    if (rx_rate == `RFO_RATE_16) begin
      eof_max_nxt = `RFO_EOF_MAX_LONG;
    end
    phc_nxt = type_b_r[`RFO_TB_PHC];
    case (type_b_r[`RFO_TB_PRE_HI:`RFO_TB_PRE_LO])
      2'b00: begin
        pre_nxt = `RFO_PRE_BASE;
      end
      2'b01: begin
        pre_nxt = `RFO_PRE_BASE + `RFO_PRE_STEP;
      end
      2'b10: begin
        pre_nxt = `RFO_PRE_BASE + (`RFO_PRE_STEP << 1);
      end
      default: begin
        pre_nxt = `RFO_PRE_BASE + `RFO_PRE_STEP + (`RFO_PRE_STEP << 1);
      end
    endcase

    crc_chk_nxt = !aux_r[`RFO_AX_NO_CRC];
    // short frames carry no CRC, so the check is forced off
    if (reqa_wupa_sent || anticollision_frame) begin
      crc_chk_nxt = 1'b0;
    end
    crc_fifo_nxt = aux_r[`RFO_AX_CRC_FIFO];
    // modulation select
    // Preset and host writes both land in the register first
    am_nxt = aux_r[`RFO_AX_AM];
    fd_nxt = aux_r[`RFO_AX_FD];
    // tristate only while OOK keys; AM masks it
    if (aux_r[`RFO_AX_TRI] && !aux_r[`RFO_AX_AM]) begin
      tri_nxt = ook_keying;
    end else begin
      tri_nxt = 1'b0;
    end
    // receive tolerance
    // Tolerant decoders are the reset choice
    tol_nxt = aux_r[`RFO_AX_TOL];
    n_nxt = aux_r[`RFO_AX_N_HI:`RFO_AX_N_LO];

    // stream decode, already registered once in the helper
    sc_div_nxt = sc_w;
    pulse_cnt_nxt = pl_w;
    tx_div_nxt = tx_w;
    code_bad_nxt = bad_w;
  end

  // Framing controls, registered so every output leaves a flip-flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      min_response_gap <= `RFO_GAP_LONG;
      accept_no_sof <= 1'b0;
      accept_no_eof <= 1'b0;
      eof_min_etu <= `RFO_EOF_MIN;
      eof_max_etu <= `RFO_EOF_MAX_SHORT;
      phase_change_tolerance <= 1'b0;
      preamble_len <= `RFO_PRE_BASE;
      rx_crc_check <= 1'b1;
      crc_to_fifo <= 1'b0;
      tx_modulation_select <= 1'b0;
      field_detector_enable <= 1'b0;
      driver_tristate <= 1'b0;
      rx_tolerant <= 1'b1;
      field_cmd_n <= 2'b00;
      subcarrier_div_log2 <= 3'd6;
      pulses_per_period <= 4'd1;
      tx_div_log2 <= 3'd7;
      stream_code_bad <= 1'b1;
    end else begin
      min_response_gap <= gap_nxt;
      accept_no_sof <= no_sof_nxt;
      accept_no_eof <= no_eof_nxt;
      eof_min_etu <= eof_min_nxt;
      eof_max_etu <= eof_max_nxt;
      phase_change_tolerance <= phc_nxt;
      preamble_len <= pre_nxt;
      rx_crc_check <= crc_chk_nxt;
      crc_to_fifo <= crc_fifo_nxt;
      tx_modulation_select <= am_nxt;
      field_detector_enable <= fd_nxt;
      driver_tristate <= tri_nxt;
      rx_tolerant <= tol_nxt;
      field_cmd_n <= n_nxt;
      subcarrier_div_log2 <= sc_div_nxt;
      pulses_per_period <= pulse_cnt_nxt;
      tx_div_log2 <= tx_div_nxt;
      stream_code_bad <= code_bad_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== sim/rfo_bank_chk.sv ====
// Port checker for the framing option bank.
// Assumes a bind onto rfo_bank with one pclk domain.
`timescale 1ns/1ns
`default_nettype none
module rfo_bank_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire [31:0] prdata,
  input wire reqa_wupa_sent,
  input wire anticollision_frame,
  input wire [1:0] rx_rate,
  input wire ook_keying,
  input wire [7:0] min_response_gap,
  input wire [3:0] eof_max_etu,
  input wire [6:0] preamble_len,
  input wire rx_crc_check,
  input wire tx_modulation_select,
  input wire driver_tristate,
  input wire [3:0] pulses_per_period
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_answer_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("pready late or too long");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  upper_zero_a: assert property (prdata[31:8] == 24'h0) else $error("prdata upper bits set");
  gap_rate_a: assert property (min_response_gap != 8'h50 |->
    min_response_gap == (($past(rx_rate) == 2'h0) ? 8'h40 : 8'h20)) else $error("gap wrong for rate");
  eof_fast_a: assert property (rx_rate == 2'h3 |=> eof_max_etu == 4'hC) else $error("eof max not 12");
  preamble_set_a: assert property (preamble_len[3:0] == 4'h0 && preamble_len[6:4] inside {3, 4, 5, 6})
    else $error("preamble length off table");
  crc_forced_a: assert property (reqa_wupa_sent || anticollision_frame |=> !rx_crc_check)
    else $error("crc check not suppressed");
  tristate_ook_a: assert property (driver_tristate |-> $past(ook_keying) && !tx_modulation_select)
    else $error("tristate outside ook");
  pulse_pow_a: assert property ($onehot(pulses_per_period)) else $error("pulse count not power of two");
  cover property (pslverr);
  cover property (driver_tristate);
  cover property (min_response_gap == 8'h20);
endmodule
bind rfo_bank rfo_bank_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .prdata,
  .reqa_wupa_sent, .anticollision_frame, .rx_rate, .ook_keying, .min_response_gap, .eof_max_etu,
  .preamble_len, .rx_crc_check, .tx_modulation_select, .driver_tristate, .pulses_per_period);
`default_nettype wire

// ==== sim/tb_rfo_bank.sv ====
// Self-checking bench for the framing option bank.
// Assumes rfo_bank and its bound checker; APB master in the bench.
`timescale 1ns/1ns
`default_nettype none
module tb_rfo_bank;
  logic pclk, presetn, psel, penable, pwrite, sdef, apc, apam, reqa, acf, bpsk, ook, pready, pslverr, e;
  logic nsof, neof, phc, crc, c2f, am, fd, trs, tol, bad;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, d;
  logic [1:0] rate, n;
  logic [7:0] gap;
  logic [3:0] emin, emax, pul, strb;
  logic [6:0] pre;
  logic [2:0] sdiv, tdiv;
  integer seed = 14905, error_cnt = 0, checks_done = 0, i;
  rfo_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .set_default_cmd(sdef), .analog_preset_cmd(apc), .analog_preset_am(apam), .reqa_wupa_sent(reqa),
    .anticollision_frame(acf), .bpsk_mode(bpsk), .rx_rate(rate), .ook_keying(ook),
    .min_response_gap(gap), .accept_no_sof(nsof), .accept_no_eof(neof), .eof_min_etu(emin),
    .eof_max_etu(emax), .phase_change_tolerance(phc), .preamble_len(pre), .rx_crc_check(crc),
    .crc_to_fifo(c2f), .tx_modulation_select(am), .field_detector_enable(fd), .driver_tristate(trs),
    .rx_tolerant(tol), .field_cmd_n(n), .subcarrier_div_log2(sdiv), .pulses_per_period(pul),
    .tx_div_log2(tdiv), .stream_code_bad(bad));
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks_done = checks_done + 1;
    if (got !== ex) begin
      error_cnt = error_cnt + 1;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Idle cycle first, so psel is never assigned twice in one step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] ex, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, ex, r);
  endtask
  function automatic logic [7:0] gap_exp(input logic [7:0] v, input logic [1:0] rt);
    return (v[7:6] == 2'h1) ? ((rt == 2'h0) ? 8'h40 : 8'h20) : 8'h50;
  endfunction
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Far above the thousand or so cycles the tests need
  initial begin
    #800000;
    error_cnt = error_cnt + 1;
    test_done;
  end
  initial begin
    {presetn, psel, penable, pwrite, sdef, apc, apam, reqa, acf, bpsk, ook} = 11'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    strb = 4'hF;
    rate = 2'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h01C, 32'h0, "type_b");
    rd(12'h020, 32'h0, "stream");
    rd(12'h024, 32'h4, "aux");
    $display("test reset done");
    for (i = 0; i < 32; i = i + 1) begin
      d = $random(seed) & 32'hFF;
      d[7:6] = i[1:0];
      d[1:0] = i[3:2];
      rate <= i[4:3];
      apb(1'b1, 12'h01C, d);
      repeat (3) @(posedge pclk);
      chk("gap", gap_exp(d[7:0], i[4:3]), gap);
      chk("no_sof", d[5], nsof);
      chk("no_eof", d[4], neof);
      chk("eof_min", 10, emin);
      chk("eof_max", (d[3] || i[4:3] == 3) ? 12 : 11, emax);
      chk("phc", d[2], phc);
      chk("preamble", 48 + 16 * d[1:0], pre);
      rd(12'h01C, d, "type_b");
    end
    $display("test type_b done");
    for (i = 0; i < 32; i = i + 1) begin
      d = $random(seed) & 32'hFF;
      bpsk <= i[0];
      apb(1'b1, 12'h020, d);
      repeat (4) @(posedge pclk);
      chk("sc_div", i[0] ? 4 - d[6:5] : 6 - d[6:5], sdiv);
      chk("pulses", 1 << d[4:3], pul);
      chk("tx_div", 7 - d[2:0], tdiv);
      chk("bad", (i[0] && d[6:5] == 3) || (!i[0] && d[4:3] == 0) || d[2:0] == 7, bad);
      rd(12'h020, d & 32'h7F, "stream");
    end
    $display("test stream done");
    for (i = 0; i < 24; i = i + 1) begin
      d = $random(seed) & 32'hFF;
      reqa <= (i % 3 == 1);
      acf <= (i % 3 == 2);
      ook <= i[0];
      apb(1'b1, 12'h024, d);
      repeat (3) @(posedge pclk);
      chk("crc", !(d[7] || i % 3 != 0), crc);
      chk("crc_fifo", d[6], c2f);
      chk("am", d[5], am);
      chk("fd", d[4], fd);
      chk("tristate", d[3] && !d[5] && i[0], trs);
      chk("tol", d[2], tol);
      chk("n", d[1:0], n);
    end
    for (i = 0; i < 2; i = i + 1) begin
      apam <= ~i[0];
      apc <= 1'b1;
      @(posedge pclk);
      apc <= 1'b0;
      rd(12'h024, {d[31:6], ~i[0], d[4:0]}, "preset");
    end
    $display("test aux done");
    apb(1'b1, 12'h028, 32'hFF);
    chk("err_wr", 1, e);
    rd(12'h02C, 32'h0, "unmapped");
    chk("err_rd", 1, e);
    sdef <= 1'b1;
    @(posedge pclk);
    sdef <= 1'b0;
    rd(12'h01C, 32'h0, "dflt_b");
    rd(12'h020, 32'h0, "dflt_s");
    rd(12'h024, 32'h4, "dflt_a");
    strb <= 4'h0;
    apb(1'b1, 12'h01C, 32'hFF);
    strb <= 4'hF;
    rd(12'h01C, 32'h0, "strb_off");
    $display("test default done");
    test_done;
  end
endmodule
`default_nettype wire
